// >>> plpc_pkg.sv
// Constants for the loopback, power-mode and low-power-idle control block.
// Assumes a 40 MHz core clock and a link-side clock fed from the MAC transmit clock.
package plpc_pkg;
   localparam int CLK_MHZ = 40;
   // Speed select codes formed as {force_msb, force_lsb}.
   localparam logic [1:0] SPEED_10 = 2'h0;
   localparam logic [1:0] SPEED_100 = 2'h1;
   localparam logic [1:0] SPEED_1000 = 2'h2;
   // Mode strap codes.
   localparam logic [3:0] STRAP_NAND = 4'h4;
   localparam logic [3:0] STRAP_CPD = 4'h7;
   // Idle patterns on the transmit data bus and on the receive data bus toward the MAC.
   localparam logic [7:0] LPI_TXD_GMII = 8'h01;
   localparam logic [3:0] LPI_TXD_MII = 4'h1;
   localparam logic [7:0] LPI_RXD = 8'h01;
   // Refresh timing inside low-power idle.
   localparam int REFRESH_US = 200;
   localparam int QUIET_MS = 20;
   localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;
   localparam int QUIET_CYC = QUIET_MS * 1000 * CLK_MHZ;
   localparam int WAKE_US = 16;
   localparam int WAKE_CYC = WAKE_US * CLK_MHZ - 1;
   // Receive clock gating after idle entry, in receive clock cycles.
   localparam logic [3:0] RXCLK_STOP_CYC = 4'h9;
   // Soft reset length in core cycles.
   localparam logic [3:0] SOFT_RST_CYC = 4'h8;
   // Energy-detect link pulse spacing: normal and stretched.
   localparam logic [15:0] PULSE_GAP_NORM = 16'h3E80;
   localparam logic [15:0] PULSE_GAP_ENERGY_DETECT_POWER_DOWN = 16'hFA00;
   // Activity blink half period.
   localparam logic [19:0] BLINK_CYC = 20'hF4240;
   localparam int TDR_W = 8;
endpackage : plpc_pkg

// >>> plpc_ctrl.sv
// Loopback, power-down and low-power-idle control for a triple-speed transceiver.
// Assumes control bits arrive as plain levels on clk; the MAC-side bus runs on link_clk.
`timescale 1ns/1ps
`default_nettype none
module plpc_ctrl (
   input wire logic clk, // Core clock, 40 MHz.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic link_clk, // MAC-side transmit/receive clock.
   input wire logic [3:0] mode_strap, // Mode strap pins.
   input wire logic led_tricolor, // Indicator strap: tri-color dual mode.
   input wire logic ctl_soft_reset, // Soft reset request level.
   input wire logic ctl_local_loopback, // Local loopback enable.
   input wire logic ctl_speed_msb, // Speed select high bit.
   input wire logic ctl_speed_lsb, // Speed select low bit.
   input wire logic ctl_autoneg_en, // Auto-negotiation enable.
   input wire logic ctl_full_duplex, // Forced full duplex.
   input wire logic ctl_power_down, // Software power down.
   input wire logic ctl_remote_loopback, // Remote loopback enable.
   input wire logic ctl_energy_detect_power_down_en, // Energy-detect power down enable.
   input wire logic ctl_10te_en, // Reduced-amplitude 10 Mbps enable.
   input wire logic ctl_eee_adv_1000, // EEE advertise gigabit.
   input wire logic ctl_eee_adv_100, // EEE advertise 100 Mbps.
   input wire logic ctl_an_restart, // Negotiation restart level.
   input wire logic ctl_tdr_start, // Cable test start.
   input wire logic tdr_echo_valid, // Reflection seen by analog front end.
   input wire logic tdr_echo_negative, // Reflection polarity inverted.
   input wire logic line_link_up, // Line link status.
   input wire logic line_energy, // Energy on the line.
   input wire logic line_lpi_code, // Sleep/refresh codes from the partner.
   input wire logic line_rx_dv, // Line receive data valid.
   input wire logic line_rx_er, // Line receive error.
   input wire logic [7:0] line_rxd, // Line receive data.
   input wire logic mac_tx_en, // MAC transmit enable.
   input wire logic mac_tx_er, // MAC transmit error.
   input wire logic [7:0] mac_txd, // MAC transmit data.
   input wire logic [16:0] nand_pins, // NAND-tree input pins.
   output logic mac_rx_dv, // MAC receive data valid.
   output logic mac_rx_er, // MAC receive error.
   output logic [7:0] mac_rxd, // MAC receive data.
   output logic mac_rx_clk_en, // Receive clock gate toward MAC.
   output logic line_tx_en, // Line transmit enable.
   output logic line_tx_er, // Line transmit error.
   output logic [7:0] line_txd, // Line transmit data.
   output logic line_tx_low_amp, // Reduced transmit amplitude.
   output logic link_pulse, // Link pulse strobe.
   output logic refresh_burst, // Refresh burst active.
   output logic [1:0] speed_sel, // Resolved speed code.
   output logic full_duplex, // Resolved duplex.
   output logic soft_reset_busy, // Soft reset in progress.
   output logic powered_down, // Core functions disabled.
   output logic energy_detect_power_down_active, // Energy-detect power down active.
   output logic eee_enabled, // EEE in effect.
   output logic tx_lpi, // Transmit idle state.
   output logic rx_lpi, // Receive idle state.
   output logic nand_mode, // NAND-tree test mode.
   output logic ref_clock_out, // Reference clock pin, NAND result in test.
   output logic tdr_open, // Cable test: open.
   output logic tdr_short, // Cable test: short.
   output logic [7:0] tdr_distance, // Cable test return time.
   output logic link_indicator_out, // Link indicator.
   output logic activity_indicator_out // Activity indicator.
);
   // ==========================================================
   // Reset release and strap capture
   logic [1:0] rst_sync_q;
   logic rst_n;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) rst_sync_q <= 2'h0;
      else rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   logic strap_taken_q, cpd_q, nand_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_taken_q <= 1'b0;
         cpd_q <= 1'b0;
         nand_q <= 1'b0;
      end else if (!strap_taken_q) begin
         strap_taken_q <= 1'b1;
         cpd_q <= (mode_strap == plpc_pkg::STRAP_CPD);
         nand_q <= (mode_strap == plpc_pkg::STRAP_NAND);
      end
   end

   // ==========================================================
   // Control synchronisers and soft reset
   localparam int NCTL = 14;
   logic [NCTL-1:0] ctl_raw, ctl_s1_q, ctl_q;
   assign ctl_raw = {ctl_soft_reset, ctl_local_loopback, ctl_speed_msb, ctl_speed_lsb,
                     ctl_autoneg_en, ctl_full_duplex, ctl_power_down, ctl_remote_loopback,
                     ctl_energy_detect_power_down_en, ctl_10te_en, ctl_eee_adv_1000, ctl_eee_adv_100,
                     ctl_an_restart, ctl_tdr_start};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_s1_q <= '0;
         ctl_q <= '0;
      end else begin
         ctl_s1_q <= ctl_raw;
         ctl_q <= ctl_s1_q;
      end
   end
   logic c_srst, c_llb, c_an, c_fd, c_pd, c_rlb, c_energy_detect_power_down, c_10te, c_restart, c_tdr;
   logic [1:0] c_speed;
   assign c_srst = ctl_q[13];
   assign c_llb = ctl_q[12];
   assign c_speed = ctl_q[11:10];
   assign c_an = ctl_q[9];
   assign c_fd = ctl_q[8];
   assign c_pd = ctl_q[7];
   assign c_rlb = ctl_q[6];
   assign c_energy_detect_power_down = ctl_q[5];
   assign c_10te = ctl_q[4];
   assign c_restart = ctl_q[1];
   assign c_tdr = ctl_q[0];

   logic [3:0] srst_cnt_q;
   logic srst_prev_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         srst_cnt_q <= 4'h0;
         srst_prev_q <= 1'b0;
      end else begin
         srst_prev_q <= c_srst;
         if (c_srst && !srst_prev_q) srst_cnt_q <= plpc_pkg::SOFT_RST_CYC;
         else if (srst_cnt_q != 4'h0) srst_cnt_q <= srst_cnt_q - 4'h1;
      end
   end
   logic srst_active;
   assign srst_active = (srst_cnt_q != 4'h0);

   // ==========================================================
   // Mode resolution
   logic llb_d, rlb_d, pd_d, energy_detect_power_down_d, eee_q;
   assign llb_d = c_llb && !srst_active;
   assign rlb_d = c_rlb && !srst_active && speed_sel == plpc_pkg::SPEED_1000
                  && full_duplex && line_link_up;
   assign pd_d = cpd_q || (c_pd && !srst_active);
   assign energy_detect_power_down_d = c_energy_detect_power_down && c_an && !line_link_up && !pd_d;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         speed_sel <= plpc_pkg::SPEED_10;
         full_duplex <= 1'b0;
         powered_down <= 1'b0;
         energy_detect_power_down_active <= 1'b0;
         soft_reset_busy <= 1'b0;
         nand_mode <= 1'b0;
         line_tx_low_amp <= 1'b0;
         eee_q <= 1'b0;
      end else begin
         speed_sel <= (!c_an && !srst_active) ? c_speed : plpc_pkg::SPEED_1000;
         full_duplex <= (c_an || c_fd) && !srst_active;
         powered_down <= pd_d;
         energy_detect_power_down_active <= energy_detect_power_down_d;
         soft_reset_busy <= srst_active;
         nand_mode <= nand_q;
         line_tx_low_amp <= c_10te && speed_sel == plpc_pkg::SPEED_10;
         if (srst_active) eee_q <= 1'b0;
         else if (c_restart) eee_q <= ctl_q[3] || ctl_q[2];
      end
   end
   assign eee_enabled = eee_q;

   // ==========================================================
   // Energy-detect link pulses: spacing stretched while in energy-detect power down.
   logic [15:0] pulse_cnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_cnt_q <= 16'h0;
         link_pulse <= 1'b0;
      end else begin
         link_pulse <= 1'b0;
         if (pulse_cnt_q == 16'h0) begin
            link_pulse <= !line_link_up && !powered_down;
            pulse_cnt_q <= energy_detect_power_down_active ? plpc_pkg::PULSE_GAP_ENERGY_DETECT_POWER_DOWN
                                       : plpc_pkg::PULSE_GAP_NORM;
         end else pulse_cnt_q <= pulse_cnt_q - 16'h1;
      end
   end

   // ==========================================================
   // Cable test: polarity classifies the fault, elapsed time gives distance.
   logic tdr_run_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tdr_run_q <= 1'b0;
         tdr_open <= 1'b0;
         tdr_short <= 1'b0;
         tdr_distance <= 8'h0;
      end else if (c_tdr && !tdr_run_q && !tdr_open && !tdr_short) begin
         tdr_run_q <= 1'b1;
         tdr_distance <= 8'h0;
      end else if (tdr_run_q) begin
         if (tdr_echo_valid) begin
            tdr_run_q <= 1'b0;
            tdr_open <= !tdr_echo_negative;
            tdr_short <= tdr_echo_negative;
         end else if (tdr_distance != 8'hFF) tdr_distance <= tdr_distance + 8'h1;
      end else if (!c_tdr) begin
         tdr_open <= 1'b0;
         tdr_short <= 1'b0;
      end
   end

   // ==========================================================
   // Refresh cadence in the core domain
   logic tx_lpi_lk_q, rx_lpi_lk_q;
   logic [1:0] txlpi_sync_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) txlpi_sync_q <= 2'h0;
      else txlpi_sync_q <= {txlpi_sync_q[0], tx_lpi_lk_q};
   end
   logic [19:0] ref_cnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_cnt_q <= 20'h0;
         refresh_burst <= 1'b0;
      end else if (!txlpi_sync_q[1]) begin
         ref_cnt_q <= 20'h0;
         refresh_burst <= 1'b0;
      end else if (refresh_burst) begin
         if (ref_cnt_q == 20'(plpc_pkg::REFRESH_CYC - 1)) begin
            refresh_burst <= 1'b0;
            ref_cnt_q <= 20'h0;
         end else ref_cnt_q <= ref_cnt_q + 20'h1;
      end else if (ref_cnt_q == 20'(plpc_pkg::QUIET_CYC - 1)) begin
         refresh_burst <= 1'b1;
         ref_cnt_q <= 20'h0;
      end else ref_cnt_q <= ref_cnt_q + 20'h1;
   end

   // ==========================================================
   // Link-side datapath on link_clk
   logic [1:0] lk_rst_q;
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) lk_rst_q <= 2'h0;
      else lk_rst_q <= {lk_rst_q[0], 1'b1};
   end
   logic [4:0] lk_cfg_s1_q, lk_cfg_q;
   always_ff @(posedge link_clk or negedge lk_rst_q[1]) begin
      if (!lk_rst_q[1]) begin
         lk_cfg_s1_q <= '0;
         lk_cfg_q <= '0;
      end else begin
         lk_cfg_s1_q <= {llb_d, rlb_d, powered_down, eee_q, speed_sel == plpc_pkg::SPEED_1000};
         lk_cfg_q <= lk_cfg_s1_q;
      end
   end
   logic lk_llb, lk_rlb, lk_pd, lk_eee, lk_gig, tx_pat;
   assign {lk_llb, lk_rlb, lk_pd, lk_eee, lk_gig} = lk_cfg_q;
   assign tx_pat = !mac_tx_en && mac_tx_er && (lk_gig ? mac_txd == plpc_pkg::LPI_TXD_GMII
                   : mac_txd[3:0] == plpc_pkg::LPI_TXD_MII);

   logic [3:0] rx_idle_cnt_q;
   always_ff @(posedge link_clk or negedge lk_rst_q[1]) begin
      if (!lk_rst_q[1]) begin
         tx_lpi_lk_q <= 1'b0;
         rx_lpi_lk_q <= 1'b0;
         rx_idle_cnt_q <= 4'h0;
         mac_rx_clk_en <= 1'b1;
      end else begin
         tx_lpi_lk_q <= lk_eee && !lk_llb && tx_pat;
         rx_lpi_lk_q <= lk_eee && !lk_llb && line_lpi_code;
         if (!rx_lpi_lk_q) rx_idle_cnt_q <= 4'h0;
         else if (rx_idle_cnt_q != plpc_pkg::RXCLK_STOP_CYC) rx_idle_cnt_q <= rx_idle_cnt_q + 4'h1;
         mac_rx_clk_en <= !(rx_lpi_lk_q && line_lpi_code
                            && rx_idle_cnt_q == plpc_pkg::RXCLK_STOP_CYC);
      end
   end
   assign tx_lpi = tx_lpi_lk_q;
   assign rx_lpi = rx_lpi_lk_q;

   always_ff @(posedge link_clk or negedge lk_rst_q[1]) begin
      if (!lk_rst_q[1]) begin
         mac_rx_dv <= 1'b0;
         mac_rx_er <= 1'b0;
         mac_rxd <= 8'h0;
         line_tx_en <= 1'b0;
         line_tx_er <= 1'b0;
         line_txd <= 8'h0;
      end else if (lk_pd) begin
         mac_rx_dv <= 1'b0;
         mac_rx_er <= 1'b0;
         mac_rxd <= 8'h0;
         line_tx_en <= 1'b0;
         line_tx_er <= 1'b0;
         line_txd <= 8'h0;
      end else if (lk_llb) begin
         mac_rx_dv <= mac_tx_en;
         mac_rx_er <= mac_tx_er;
         mac_rxd <= mac_txd;
         line_tx_en <= 1'b0;
         line_tx_er <= 1'b0;
         line_txd <= 8'h0;
      end else if (lk_rlb) begin
         line_tx_en <= line_rx_dv;
         line_tx_er <= line_rx_er;
         line_txd <= line_rxd;
         mac_rx_dv <= 1'b0;
         mac_rx_er <= 1'b0;
         mac_rxd <= 8'h0;
      end else begin
         line_tx_en <= mac_tx_en;
         line_tx_er <= mac_tx_er;
         line_txd <= mac_txd;
         if (lk_eee && line_lpi_code) begin
            mac_rx_dv <= 1'b0;
            mac_rx_er <= 1'b1;
            mac_rxd <= plpc_pkg::LPI_RXD;
         end else begin
            mac_rx_dv <= line_rx_dv;
            mac_rx_er <= line_rx_er;
            mac_rxd <= line_rxd;
         end
      end
   end

   // ==========================================================
   // NAND tree and indicators
   logic [1:0] act_sync_q;
   logic [16:0] nand_s1_q, nand_s2_q;
   logic [19:0] blink_cnt_q;
   logic blink_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         act_sync_q <= 2'h0;
         nand_s1_q <= '0;
         nand_s2_q <= '0;
         ref_clock_out <= 1'b0;
         blink_cnt_q <= 20'h0;
         blink_q <= 1'b0;
         link_indicator_out <= 1'b1;
         activity_indicator_out <= 1'b1;
      end else begin
         act_sync_q <= {act_sync_q[0], line_rx_dv | mac_tx_en};
         nand_s1_q <= nand_pins;
         nand_s2_q <= nand_s1_q;
         ref_clock_out <= nand_q ? !(&nand_s2_q) : 1'b0;
         if (blink_cnt_q == plpc_pkg::BLINK_CYC) begin
            blink_cnt_q <= 20'h0;
            blink_q <= !blink_q;
         end else blink_cnt_q <= blink_cnt_q + 20'h1;
         if (!line_link_up || powered_down) begin
            link_indicator_out <= 1'b1;
            activity_indicator_out <= 1'b1;
         end else if (led_tricolor && speed_sel == plpc_pkg::SPEED_10) begin
            link_indicator_out <= act_sync_q[1] & blink_q;
            activity_indicator_out <= act_sync_q[1] & blink_q;
         end else if (led_tricolor) begin
            link_indicator_out <= speed_sel == plpc_pkg::SPEED_1000
                                  ? act_sync_q[1] & blink_q : 1'b1;
            activity_indicator_out <= speed_sel == plpc_pkg::SPEED_100
                                      ? act_sync_q[1] & blink_q : 1'b1;
         end else begin
            link_indicator_out <= 1'b0;
            activity_indicator_out <= !(act_sync_q[1] & blink_q);
         end
      end
   end

   // ==========================================================
   // Checks
   AST_LLB_ECHO: assert property (@(posedge link_clk) disable iff (!lk_rst_q[1])
      (lk_llb && !lk_pd) |=> (mac_rx_dv == $past(mac_tx_en) && !line_tx_en))
      else $error("loopback echo wrong");
   AST_TX_LPI: assert property (@(posedge link_clk) disable iff (!lk_rst_q[1])
      (lk_eee && !lk_llb && tx_pat) |=> tx_lpi_lk_q)
      else $error("tx idle not entered");
   AST_TX_LPI_EXIT: assert property (@(posedge link_clk) disable iff (!lk_rst_q[1])
      (tx_lpi_lk_q && !tx_pat) |=> !tx_lpi_lk_q)
      else $error("tx idle not left");
   AST_RX_LPI_OUT: assert property (@(posedge link_clk) disable iff (!lk_rst_q[1])
      (lk_eee && line_lpi_code && !lk_llb && !lk_rlb && !lk_pd) |=>
      (!mac_rx_dv && mac_rx_er && mac_rxd == 8'h01))
      else $error("rx idle pattern wrong");
   AST_RXCLK_STOP: assert property (@(posedge link_clk) disable iff (!lk_rst_q[1])
      !mac_rx_clk_en |-> $past(rx_lpi_lk_q, 1) && rx_idle_cnt_q >= 4'h9)
      else $error("rx clock stopped early");
   AST_SRST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
      ($rose(c_srst)) |=> srst_active ##8 !srst_active)
      else $error("soft reset not self-clearing");
   AST_ENERGY_DETECT_POWER_DOWN: assert property (@(posedge clk) disable iff (!rst_n)
      energy_detect_power_down_active |-> $past(c_an) && !$past(line_link_up))
      else $error("energy_detect_power_down with link or no negotiation");
   AST_PD: assert property (@(posedge clk) disable iff (!rst_n)
      (c_pd && !srst_active) |=> powered_down)
      else $error("power down not entered");
   AST_SPEED: assert property (@(posedge clk) disable iff (!rst_n)
      (!c_an && !srst_active) |=> speed_sel == $past(c_speed))
      else $error("forced speed wrong");
   AST_REFRESH: assert property (@(posedge clk) disable iff (!rst_n)
      !txlpi_sync_q[1] |=> !refresh_burst)
      else $error("refresh outside idle");
endmodule : plpc_ctrl
`default_nettype wire

// >>> plpc_mac_model.sv
// MAC-side model: drives the transmit bus toward the block.
// Assumes link_clk is the transmit clock and mode is a slow level.
`timescale 1ns/1ps
`default_nettype none
module plpc_mac_model (
   input wire logic link_clk, // Transmit clock.
   input wire logic [1:0] mode, // 0 idle, 1 data, 2 low-power idle.
   input wire logic [7:0] data, // Byte sent in data mode.
   output logic tx_en, // Transmit enable.
   output logic tx_er, // Transmit error.
   output logic [7:0] txd // Transmit data.
);
   // ==========================================================
   // Transmit bus
   // The clock is never stopped, which keeps the idle hold trivially.
   always_ff @(posedge link_clk) begin
      tx_en <= (mode == 2'h1);
      tx_er <= (mode == 2'h2);
      txd <= (mode == 2'h1) ? data : (mode == 2'h2) ? plpc_pkg::LPI_TXD_GMII : 8'h00;
   end
endmodule : plpc_mac_model
`default_nettype wire

// >>> phy_loopback_power_lpi_control_test.sv
// Self-checking bench for the loopback, power and idle control block.
// Assumes plpc_ctrl and plpc_mac_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module phy_loopback_power_lpi_control_test;
   logic clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0, line_lpi_code = 1'b0;
   logic ctl_soft_reset = 1'b0, ctl_local_loopback = 1'b0, ctl_an_restart = 1'b0;
   logic ctl_speed_msb = 1'b0, ctl_speed_lsb = 1'b0, ctl_autoneg_en = 1'b1, ctl_full_duplex = 1'b0;
   logic ctl_power_down = 1'b0, ctl_eee_adv_1000 = 1'b0, ctl_eee_adv_100 = 1'b0;
   logic ctl_remote_loopback = 1'b0, ctl_energy_detect_power_down_en = 1'b0, ctl_10te_en = 1'b0, ctl_tdr_start = 1'b0;
   logic tdr_echo_valid = 1'b0, tdr_echo_negative = 1'b0, line_link_up = 1'b1, line_rx_dv = 1'b0;
   logic line_tx_low_amp, energy_detect_power_down_active, tdr_open, tdr_short;
   logic [7:0] line_rxd = 8'h00, line_txd, tdr_distance;
   logic [1:0] mac_mode = 2'h0;
   logic [7:0] mac_data = 8'h00;
   logic mac_tx_en, mac_tx_er, mac_rx_dv, mac_rx_er, mac_rx_clk_en, line_tx_en, powered_down;
   logic soft_reset_busy, eee_enabled, tx_lpi, rx_lpi, full_duplex;
   logic [7:0] mac_txd, mac_rxd;
   logic [1:0] speed_sel;
   int n_mismatch = 0, samples_checked = 0, cycles = 0;
   // ==========================================================
   // Clocks, partner and block
   always #12.5 clk = ~clk;
   always #3 link_clk = ~link_clk;
   plpc_mac_model mac_u (.link_clk, .mode(mac_mode), .data(mac_data), .tx_en(mac_tx_en),
      .tx_er(mac_tx_er), .txd(mac_txd));
   plpc_ctrl dut_u (.clk, .reset_n, .link_clk, .mode_strap(4'h1), .led_tricolor(1'b0),
      .ctl_soft_reset, .ctl_local_loopback, .ctl_speed_msb, .ctl_speed_lsb, .ctl_autoneg_en,
      .ctl_full_duplex, .ctl_power_down, .ctl_remote_loopback, .ctl_energy_detect_power_down_en,
      .ctl_10te_en, .ctl_eee_adv_1000, .ctl_eee_adv_100, .ctl_an_restart,
      .ctl_tdr_start, .tdr_echo_valid, .tdr_echo_negative,
      .line_link_up, .line_energy(1'b1), .line_lpi_code, .line_rx_dv,
      .line_rx_er(1'b0), .line_rxd, .mac_tx_en, .mac_tx_er, .mac_txd,
      .nand_pins(17'h1FFFF), .mac_rx_dv, .mac_rx_er, .mac_rxd, .mac_rx_clk_en, .line_tx_en,
      .line_tx_er(), .line_txd, .line_tx_low_amp, .link_pulse(), .refresh_burst(),
      .speed_sel, .full_duplex, .soft_reset_busy, .powered_down, .energy_detect_power_down_active,
      .eee_enabled, .tx_lpi, .rx_lpi, .nand_mode(), .ref_clock_out(), .tdr_open,
      .tdr_short, .tdr_distance, .link_indicator_out(), .activity_indicator_out());
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   // ==========================================================
   // Scenarios
   task automatic t_speed;
      ctl_autoneg_en <= 1'b0;
      ctl_full_duplex <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         {ctl_speed_msb, ctl_speed_lsb} <= i[1:0];
         settle(8);
         check(speed_sel, i[7:0]);
      end
      check(full_duplex, 8'h01);
      $display("speed test done");
   endtask : t_speed
   task automatic t_loop;
      // The host has already chosen manual slave; this block has no such control.
      ctl_local_loopback <= 1'b1;
      settle(8);
      @(posedge clk);
      mac_mode <= 2'h1;
      mac_data <= 8'hA5;
      settle(2);
      check(mac_rx_dv, 8'h01);
      check(mac_rxd, 8'hA5);
      check(line_tx_en, 8'h00);
      @(posedge clk);
      mac_mode <= 2'h0;
      ctl_local_loopback <= 1'b0;
      settle(8);
      check(mac_rx_dv, 8'h00);
      $display("loopback test done");
   endtask : t_loop
   task automatic t_power;
      ctl_power_down <= 1'b1;
      settle(8);
      check(powered_down, 8'h01);
      @(posedge clk);
      ctl_power_down <= 1'b0;
      settle(8);
      check(powered_down, 8'h00);
      $display("power test done");
   endtask : t_power
   task automatic t_eee;
      check(eee_enabled, 8'h00);
      ctl_eee_adv_1000 <= 1'b1;
      ctl_eee_adv_100 <= 1'b1;
      ctl_an_restart <= 1'b1;
      settle(8);
      ctl_an_restart <= 1'b0;
      check(eee_enabled, 8'h01);
      mac_mode <= 2'h2;
      settle(2);
      check(tx_lpi, 8'h01);
      check(rx_lpi, 8'h00);
      line_lpi_code <= 1'b1;
      settle(2);
      check(rx_lpi, 8'h01);
      check({mac_rx_dv, mac_rx_er}, 8'h01);
      check(mac_rxd, plpc_pkg::LPI_RXD);
      settle(2);
      check(mac_rx_clk_en, 8'h00);
      mac_mode <= 2'h0;
      settle(1);
      check(tx_lpi, 8'h00);
      line_lpi_code <= 1'b0;
      settle(1);
      check(rx_lpi, 8'h00);
      $display("idle test done");
   endtask : t_eee
   task automatic t_soft;
      ctl_soft_reset <= 1'b1;
      settle(4);
      check(soft_reset_busy, 8'h01);
      settle(10);
      ctl_soft_reset <= 1'b0;
      check(soft_reset_busy, 8'h00);
      $display("soft reset test done");
   endtask : t_soft
   task automatic t_remote;
      ctl_remote_loopback <= 1'b1;
      line_rx_dv <= 1'b1;
      line_rxd <= 8'h3C;
      settle(8);
      check(line_tx_en, 8'h01);
      check(line_txd, 8'h3C);
      check(mac_rx_dv, 8'h00);
      ctl_speed_msb <= 1'b0;
      ctl_10te_en <= 1'b1;
      settle(8);
      check(line_tx_en, 8'h00);
      check(mac_rx_dv, 8'h01);
      check(line_tx_low_amp, 8'h01);
      ctl_remote_loopback <= 1'b0;
      line_rx_dv <= 1'b0;
      ctl_10te_en <= 1'b0;
      ctl_speed_msb <= 1'b1;
      settle(8);
      check(line_tx_low_amp, 8'h00);
      $display("remote loopback test done");
   endtask : t_remote
   task automatic t_energy_detect_power_down;
      ctl_autoneg_en <= 1'b1;
      ctl_energy_detect_power_down_en <= 1'b1;
      line_link_up <= 1'b0;
      settle(8);
      check(energy_detect_power_down_active, 8'h01);
      line_link_up <= 1'b1;
      settle(4);
      check(energy_detect_power_down_active, 8'h00);
      $display("energy detect test done");
   endtask : t_energy_detect_power_down
   task automatic t_tdr;
      ctl_soft_reset <= 1'b1;
      settle(4);
      ctl_soft_reset <= 1'b0;
      settle(12);
      for (int p = 0; p < 2; p++) begin
         ctl_tdr_start <= 1'b1;
         tdr_echo_negative <= p[0];
         settle(8);
         tdr_echo_valid <= 1'b1;
         settle(2);
         check(tdr_open, {7'h00, !p[0]});
         check(tdr_short, {7'h00, p[0]});
         check(tdr_distance, 8'h05);
         ctl_tdr_start <= 1'b0;
         tdr_echo_valid <= 1'b0;
         settle(4);
         check(tdr_short, 8'h00);
      end
      ctl_soft_reset <= 1'b1;
      settle(4);
      ctl_soft_reset <= 1'b0;
      settle(12);
      $display("cable test done");
   endtask : t_tdr
   // ==========================================================
   // Main sequence and hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         n_mismatch++;
         conclude();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      settle(6);
      check(tx_lpi, 8'h00);
      check(mac_rx_clk_en, 8'h01);
      t_speed();
      t_loop();
      t_power();
      t_eee();
      t_soft();
      t_remote();
      t_energy_detect_power_down();
      t_tdr();
      conclude();
   end
endmodule : phy_loopback_power_lpi_control_test
`default_nettype wire
